// file: wake_cfg_pkg.sv
// package: offsets, field positions, reset values and counts for the wakeup and option registers
package wake_cfg_pkg;
    // register byte offsets
    localparam logic [7:0] port_a_off = 8'h00;
    localparam logic [7:0] key_status_off = 8'h04;
    localparam logic [7:0] key_enable_off = 8'h08;
    localparam logic [7:0] stop_ctrl_off = 8'h0c;
    localparam logic [7:0] option_two_off = 8'h1e;
    localparam logic [7:0] option_one_off = 8'h1f;
    // field positions
    localparam int latch_pos = 6;
    localparam int flag_pos = 3;
    localparam int ack_pos = 2;
    localparam int mask_pos = 1;
    localparam int wake_ie_pos = 6;
    localparam int pud_pos = 7;
    localparam int irq_pin_function_enable_pos = 6;
    localparam int osc_pos = 1;
    localparam int ser_pos = 0;
    localparam int reset_pin_function_enable_pos = 4;
    localparam int rate_pos = 7;
    localparam int short_recovery_select_pos = 6;
    // reset values
    localparam logic [7:0] option_reset = 8'h00;
    // counts
    localparam int wake_short_cycles = 512;
    localparam int wake_long_cycles = 16384;
    localparam int recov_short_cycles = 32;
    localparam int recov_long_cycles = 4096;
    localparam int wdog_short_cycles = 8176;
    localparam int wdog_long_cycles = 262128;
    typedef struct packed {
        logic pullup_disable;
        logic irq_enable;
        logic serial_src;
        logic reset_pin_enable;
        logic osc_stop;
        logic rate;
        logic short_recovery;
    } option_bits_s;
endpackage

// file: wake_cfg_regs.sv
// wakeup timer, keyboard-shared flags and write-once option registers
//
// Function
// RULE_01 - wakeup latch reads as read-only bit six of the port data register
// RULE_02 - key status bits seven to four read as zero
// RULE_03 - pending flag set by key or wake request, cleared by reset
// RULE_04 - writing one to acknowledge clears requests and latch; reads zero
// RULE_05 - mask bit set blocks interrupt requests; reset clears it
// RULE_06 - latch captures wake requests only while wake enable is one
// RULE_07 - oscillator-in-stop bit selects double-rate bus clock for wake timer
// RULE_08 - oscillator-in-stop clear disables bus clock source in stop
// RULE_09 - rate select one gives 512 wake clock periods in stop
// RULE_10 - rate select zero gives 16384 wake clock periods in stop
// RULE_11 - short recovery one leaves stop after 32 cycles, else 4096
// RULE_12 - each option register takes one write per reset, always readable
// RULE_13 - software should write option registers right after reset
// RULE_14 - option registers sit at 0x1e and 0x1f
// RULE_15 - pullup disable bit one disconnects irq pin pullup
// RULE_16 - irq function bit one enables external interrupt on pin
// RULE_17 - serial clock bit one selects bus clock, zero quad-rate clock
// RULE_18 - reset pin bit cleared by power-on reset only
// RULE_19 - outside stop, rate select sets watchdog timeout 8176 or 262128
// RULE_20 - wake counter idle outside stop, restarts from zero on stop entry
// RULE_21 - counter overflow latches wake request into the keyboard logic
// RULE_22 - reset clears latch; wake enable does not gate latch reading
// RULE_23 - per-register lock flag set by first write, cleared by reset
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module wake_cfg_regs #(
    parameter int wake_long_count = wake_cfg_pkg::wake_long_cycles,
    parameter int wdog_long_count = wake_cfg_pkg::wdog_long_cycles
)(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic por_n_in,
    input wire logic stop_mode_in,
    input wire logic rc_osc_tick_in,
    input wire logic bus2x_tick_in,
    input wire logic quad_tick_in,
    input wire logic key_request_in,
    input wire logic [4:0] port_a_pins_in,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic key_irq_out,
    output logic bus_clock_run_out,
    output logic wake_exit_out,
    output logic stop_release_out,
    output logic [17:0] watchdog_timeout_out,
    output logic [wake_cfg_pkg::short_recovery_select_pos:0] option_dummy_out,
    output wake_cfg_pkg::option_bits_s options_out
);
    // ************************************
    // bus write side
    // ************************************
    logic aw_full_reg, aw_full_next;
    logic w_full_reg, w_full_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic [7:0] w_data_reg, w_data_next;
    logic w_lane_reg, w_lane_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic wr_fire;
    logic wr_ok;

    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !w_full_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;

    always_comb
    begin
        wr_ok = 1'b1;
        case (aw_addr_reg)
            wake_cfg_pkg::port_a_off: wr_ok = 1'b1;
            wake_cfg_pkg::key_status_off: wr_ok = 1'b1;
            wake_cfg_pkg::key_enable_off: wr_ok = 1'b1;
            wake_cfg_pkg::stop_ctrl_off: wr_ok = 1'b1;
            wake_cfg_pkg::option_two_off: wr_ok = 1'b1;
            wake_cfg_pkg::option_one_off: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_lane_next = w_lane_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_full_next = 1'b1;
            w_data_next = s_axi_wdata[7:0];
            w_lane_next = s_axi_wstrb[0];
        end
        if (wr_fire)
        begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_ok ? 2'h0 : 2'h2;
        end
        if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
        end
        else
        begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_lane_reg <= w_lane_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    logic wr_go;
    assign wr_go = wr_fire && w_lane_reg;

    // ************************************
    // control and option registers
    // ************************************
    logic mask_reg, mask_next;
    logic wake_ie_reg, wake_ie_next;
    logic [7:0] opt2_reg, opt2_next;
    logic [7:0] opt1_reg, opt1_next;
    logic lock2_reg, lock2_next;
    logic lock1_reg, lock1_next;
    logic reset_pin_function_enable_reg, reset_pin_function_enable_next;
    logic ack_pulse;

    always_comb
    begin
        mask_next = mask_reg;
        wake_ie_next = wake_ie_reg;
        opt2_next = opt2_reg;
        opt1_next = opt1_reg;
        lock2_next = lock2_reg;
        lock1_next = lock1_reg;
        reset_pin_function_enable_next = reset_pin_function_enable_reg;
        ack_pulse = 1'b0;
        if (wr_go && aw_addr_reg == wake_cfg_pkg::key_status_off)
        begin
            // RULE_05 mask bit write
            mask_next = w_data_reg[wake_cfg_pkg::mask_pos];
            // RULE_04 acknowledge strobe
            ack_pulse = w_data_reg[wake_cfg_pkg::ack_pos];
        end
        if (wr_go && aw_addr_reg == wake_cfg_pkg::key_enable_off)
        begin
            wake_ie_next = w_data_reg[wake_cfg_pkg::wake_ie_pos];
        end
        // RULE_12 RULE_23 write once lock
        if (wr_go && aw_addr_reg == wake_cfg_pkg::option_two_off && !lock2_reg)
        begin
            opt2_next = w_data_reg;
            lock2_next = 1'b1;
            reset_pin_function_enable_next = w_data_reg[wake_cfg_pkg::reset_pin_function_enable_pos];
        end
        if (wr_go && aw_addr_reg == wake_cfg_pkg::option_one_off && !lock1_reg)
        begin
            opt1_next = w_data_reg;
            lock1_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            mask_reg <= 1'b0;
            wake_ie_reg <= 1'b0;
            opt2_reg <= wake_cfg_pkg::option_reset;
            opt1_reg <= wake_cfg_pkg::option_reset;
            lock2_reg <= 1'b0;
            lock1_reg <= 1'b0;
        end
        else
        begin
            mask_reg <= mask_next;
            wake_ie_reg <= wake_ie_next;
            opt2_reg <= opt2_next;
            opt1_reg <= opt1_next;
            lock2_reg <= lock2_next;
            lock1_reg <= lock1_next;
        end
    end

    // RULE_18 reset pin bit on power-on reset only
    always_ff @(posedge clk_sys_in or negedge por_n_in)
    begin
        if (!por_n_in)
        begin
            reset_pin_function_enable_reg <= 1'b0;
        end
        else
        begin
            reset_pin_function_enable_reg <= reset_pin_function_enable_next;
        end
    end

    logic osc_stop;
    logic rate_sel;
    logic short_recovery_select;
    assign osc_stop = opt2_reg[wake_cfg_pkg::osc_pos];
    assign rate_sel = opt1_reg[wake_cfg_pkg::rate_pos];
    assign short_recovery_select = opt1_reg[wake_cfg_pkg::short_recovery_select_pos];

    // RULE_15 RULE_16 RULE_17 option outputs
    always_comb
    begin
        options_out.pullup_disable = opt2_reg[wake_cfg_pkg::pud_pos];
        options_out.irq_enable = opt2_reg[wake_cfg_pkg::irq_pin_function_enable_pos];
        options_out.serial_src = opt2_reg[wake_cfg_pkg::ser_pos];
        options_out.reset_pin_enable = reset_pin_function_enable_reg;
        options_out.osc_stop = osc_stop;
        options_out.rate = rate_sel;
        options_out.short_recovery = short_recovery_select;
    end
    assign option_dummy_out = opt1_reg[wake_cfg_pkg::short_recovery_select_pos:0];

    // RULE_07 RULE_08 bus clock runs in stop only if enabled
    assign bus_clock_run_out = !stop_mode_in || osc_stop;

    // RULE_19 watchdog timeout select
    assign watchdog_timeout_out = rate_sel ? 18'(wake_cfg_pkg::wdog_short_cycles) : 18'(wdog_long_count);

    // ************************************
    // wakeup timer, latch and recovery
    // ************************************
    logic [14:0] wake_cnt_reg, wake_cnt_next;
    logic latch_reg, latch_next;
    logic flag_reg, flag_next;
    logic stop_d_reg;
    logic [12:0] rec_cnt_reg, rec_cnt_next;
    logic rec_run_reg, rec_run_next;
    logic wake_tick;
    logic wake_ovf;
    logic [14:0] wake_limit;

    // RULE_07 wake clock source select
    assign wake_tick = osc_stop ? bus2x_tick_in : rc_osc_tick_in;
    // RULE_09 RULE_10 wake period select
    assign wake_limit = rate_sel ? 15'(wake_cfg_pkg::wake_short_cycles - 1) : 15'(wake_long_count - 1);
    assign wake_ovf = stop_mode_in && wake_tick && wake_cnt_reg == wake_limit;

    always_comb
    begin
        wake_cnt_next = wake_cnt_reg;
        latch_next = latch_reg;
        flag_next = flag_reg;
        rec_cnt_next = rec_cnt_reg;
        rec_run_next = rec_run_reg;
        // RULE_20 counter idle outside stop, zero at entry
        if (!stop_mode_in)
        begin
            wake_cnt_next = 15'h0000;
        end
        else if (wake_tick)
        begin
            wake_cnt_next = wake_ovf ? 15'h0000 : wake_cnt_reg + 15'h0001;
        end
        if (ack_pulse)
        begin
            latch_next = 1'b0;
            flag_next = 1'b0;
        end
        // RULE_06 RULE_21 latch on overflow, set wins
        if (wake_ovf && wake_ie_reg)
        begin
            latch_next = 1'b1;
        end
        // RULE_03 pending flag, set wins
        if (key_request_in || (wake_ovf && wake_ie_reg))
        begin
            flag_next = 1'b1;
        end
        // RULE_11 recovery delay start
        if (stop_mode_in && !rec_run_reg && flag_reg && !mask_reg)
        begin
            rec_run_next = 1'b1;
            rec_cnt_next = short_recovery_select ? 13'(wake_cfg_pkg::recov_short_cycles) : 13'(wake_cfg_pkg::recov_long_cycles);
        end
        else if (rec_run_reg && quad_tick_in)
        begin
            rec_cnt_next = rec_cnt_reg - 13'h0001;
            if (rec_cnt_reg == 13'h0001)
            begin
                rec_run_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wake_cnt_reg <= 15'h0000;
            // RULE_22 reset clears latch
            latch_reg <= 1'b0;
            flag_reg <= 1'b0;
            stop_d_reg <= 1'b0;
            rec_cnt_reg <= 13'h0000;
            rec_run_reg <= 1'b0;
        end
        else
        begin
            wake_cnt_reg <= wake_cnt_next;
            latch_reg <= latch_next;
            flag_reg <= flag_next;
            stop_d_reg <= rec_run_reg;
            rec_cnt_reg <= rec_cnt_next;
            rec_run_reg <= rec_run_next;
        end
    end

    // RULE_05 mask gates interrupt
    assign key_irq_out = flag_reg && !mask_reg;
    assign wake_exit_out = stop_mode_in && flag_reg && !mask_reg;
    // RULE_11 release pulse after count
    assign stop_release_out = stop_d_reg && !rec_run_reg;

    // ************************************
    // bus read side
    // ************************************
    logic rvalid_reg, rvalid_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [7:0] rd_val;
    logic rd_ok;

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = {24'h000000, rdata_reg};
    assign s_axi_rresp = rresp_reg;

    always_comb
    begin
        rd_val = 8'h00;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            // RULE_01 RULE_22 latch in port data
            wake_cfg_pkg::port_a_off: rd_val = {1'b0, latch_reg, 1'b0, port_a_pins_in};
            // RULE_02 RULE_04 upper bits and acknowledge read zero
            wake_cfg_pkg::key_status_off: rd_val = {4'h0, flag_reg, 1'b0, mask_reg, 1'b0};
            wake_cfg_pkg::key_enable_off: rd_val = {1'b0, wake_ie_reg, 6'h00};
            wake_cfg_pkg::stop_ctrl_off: rd_val = {7'h00, rec_run_reg};
            // RULE_14 option register addresses
            wake_cfg_pkg::option_two_off: rd_val = {opt2_reg[7:5], reset_pin_function_enable_reg, opt2_reg[3:0]};
            wake_cfg_pkg::option_one_off: rd_val = opt1_reg;
            default: rd_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rdata_next = rd_val;
            rresp_next = rd_ok ? 2'h0 : 2'h2;
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rresp_reg <= 2'h0;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end
endmodule

// file: wake_cfg_regs_props.sv
// port-level checker for the wakeup and option register block
`timescale 1ns/1ps
module wake_cfg_regs_props #(
    parameter int wdog_long_count = 262128
)(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic stop_mode_in,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic key_irq_out,
    input wire logic bus_clock_run_out,
    input wire logic wake_exit_out,
    input wire logic stop_release_out,
    input wire logic [17:0] watchdog_timeout_out,
    input wire wake_cfg_pkg::option_bits_s options_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);
    // ****
    // last read address
    // ****
    logic [7:0] rd_addr_reg;
    logic [7:0] rd_addr_next;
    always_comb
    begin
        rd_addr_next = rd_addr_reg;
        if (s_axi_arvalid && s_axi_arready)
            rd_addr_next = s_axi_araddr;
    end
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rd_addr_reg <= 8'h00;
        else
            rd_addr_reg <= rd_addr_next;
    end
    // ****
    // properties
    // ****
    chk_clock_keep: assert property (stop_mode_in && options_out.osc_stop |-> bus_clock_run_out)
        else $error("bus clock stopped while kept for stop");
    chk_clock_stop: assert property (stop_mode_in && !options_out.osc_stop |-> !bus_clock_run_out)
        else $error("bus clock runs in stop");
    chk_wdog_period: assert property (watchdog_timeout_out == (options_out.rate ? 18'h01ff0 : 18'(wdog_long_count)))
        else $error("watchdog timeout wrong");
    chk_status_zero: assert property (s_axi_rvalid && rd_addr_reg == 8'h04 |-> s_axi_rdata[7:4] == 4'h0 && !s_axi_rdata[2])
        else $error("status upper or acknowledge bits not zero");
    chk_option_once: assert property (!$stable(options_out) |-> $rose(s_axi_bvalid))
        else $error("options changed without a write");
    chk_exit_level: assert property (wake_exit_out == (stop_mode_in && key_irq_out))
        else $error("stop exit request wrong");
    chk_release_pulse: assert property (stop_release_out |=> !stop_release_out)
        else $error("release longer than one cycle");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    cover property (stop_release_out);
    cover property (wake_exit_out);
    cover property (key_irq_out);
endmodule
bind wake_cfg_regs wake_cfg_regs_props #(.wdog_long_count(wdog_long_count)) i_wake_cfg_regs_props (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .stop_mode_in(stop_mode_in),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .key_irq_out(key_irq_out), .bus_clock_run_out(bus_clock_run_out),
    .wake_exit_out(wake_exit_out), .stop_release_out(stop_release_out),
    .watchdog_timeout_out(watchdog_timeout_out), .options_out(options_out));

// file: tb_wake_cfg_regs.sv
// self-checking bench for the wakeup and option register block
`timescale 1ns/1ps
module tb_wake_cfg_regs;
    localparam int wl = 64;
    localparam int wdl = 1000;
    logic clk = 1'b0;
    logic rst_n, por_n, stop, rco, b2x, quad, key;
    logic [4:0] pins;
    logic [7:0] awaddr, araddr, o1, o2, d;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic irq, run, wexit, rel, lat, flag, mask, en, l1, l2;
    logic [17:0] wdt;
    wake_cfg_pkg::option_bits_s opts;
    int error_cnt = 0;
    int compares = 0;
    int seed = 28;
    always #10 clk = ~clk;
    wake_cfg_regs #(.wake_long_count(wl), .wdog_long_count(wdl)) i_wake_cfg_regs (
        .clk_sys_in(clk), .reset_n_in(rst_n), .por_n_in(por_n), .stop_mode_in(stop),
        .rc_osc_tick_in(rco), .bus2x_tick_in(b2x), .quad_tick_in(quad), .key_request_in(key),
        .port_a_pins_in(pins), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .key_irq_out(irq), .bus_clock_run_out(run),
        .wake_exit_out(wexit), .stop_release_out(rel), .watchdog_timeout_out(wdt),
        .option_dummy_out(), .options_out(opts));
    // ****
    // compare and report
    // ****
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task chk_rs(input string s, input logic [1:0] e, input logic [1:0] g);
        chk(s, {30'h0, e}, {30'h0, g});
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ****
    // reference model
    // ****
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h00: exp_rd = {25'h0, lat, 1'b0, pins};
            8'h04: exp_rd = {28'h0, flag, 1'b0, mask, 1'b0};
            8'h08: exp_rd = {25'h0, en, 6'h00};
            8'h1e: exp_rd = {24'h0, o2};
            8'h1f: exp_rd = {24'h0, o1};
            default: exp_rd = 32'h0;
        endcase
    endfunction
    task outs;
        chk("irq", {31'h0, flag & ~mask}, {31'h0, irq});
        chk("exit", {31'h0, stop & flag & ~mask}, {31'h0, wexit});
        chk("run", {31'h0, ~stop | o2[1]}, {31'h0, run});
        chk("opts", {25'h0, o2[7], o2[6], o2[0], o2[4], o2[1], o1[7], o1[6]}, {25'h0, opts});
        chk("wdog", o1[7] ? 32'h1ff0 : 32'(wdl), {14'h0, wdt});
    endtask
    // ****
    // bus and stimulus tasks
    // ****
    task wr(input logic [7:0] a, input logic [7:0] v);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (!pa && !pw && bvalid)
                break;
            if (pa && awready)
            begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (pw && wready)
            begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
        end
        chk_rs("bresp", 2'b00, bresp);
        case (a)
            8'h04:
            begin
                if (v[2])
                    {lat, flag} = 2'b00;
                mask = v[1];
            end
            8'h08: en = v[6];
            8'h1e: if (!l2) {o2, l2} = {v, 1'b1};
            8'h1f: if (!l1) {o1, l1} = {v, 1'b1};
            default: ;
        endcase
    endtask
    task rc(input logic [7:0] a, input logic [31:0] m);
        logic p;
        p = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (rvalid)
                break;
            if (p && arready)
            begin
                p = 1'b0;
                arvalid <= 1'b0;
            end
        end
        chk_rs("rresp", (a == 8'h10) ? 2'b10 : 2'b00, rresp);
        chk($sformatf("reg %h", a), exp_rd(a) & m, rdata & m);
    endtask
    task tk(input int w, input int n);
        repeat (n)
        begin
            @(posedge clk);
            {quad, b2x, rco} <= 3'(1 << w);
        end
        @(posedge clk);
        {quad, b2x, rco} <= 3'h0;
        repeat (3) @(posedge clk);
    endtask
    task rec(input int e);
        int n;
        n = 0;
        quad <= 1'b1;
        while (!rel && n < 9000)
        begin
            @(posedge clk);
            n++;
        end
        quad <= 1'b0;
        chk("recovery", 32'(n >= e && n <= e + 3), 32'h1);
    endtask
    // ****
    // tests
    // ****
    initial
    begin
        {rst_n, por_n, stop, rco, b2x, quad, key} = 7'h00;
        {awvalid, wvalid, arvalid, lat, flag, mask, en, l1, l2} = 9'h000;
        {awaddr, araddr, o1, o2} = 32'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        bready = 1'b1;
        rready = 1'b1;
        pins = 5'($random(seed));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        @(posedge clk);
        rc(8'h00, 32'hffffffff);
        rc(8'h04, 32'hffffffff);
        rc(8'h08, 32'hffffffff);
        rc(8'h1e, 32'h000000d3);
        rc(8'h1f, 32'hffffffff);
        rc(8'h10, 32'hffffffff);
        outs;
        $display("test reset done");
        d = 8'($random(seed));
        wr(8'h1e, d | 8'h12);
        wr(8'h1f, d | 8'hc0);
        wr(8'h1e, ~d & 8'hed);
        wr(8'h1f, ~d & 8'h3f);
        wr(8'h08, 8'h40);
        wr(8'h04, 8'h04);
        rc(8'h1e, 32'h000000d3);
        rc(8'h1f, 32'hffffffff);
        rc(8'h04, 32'hffffffff);
        outs;
        $display("test options done");
        stop <= 1'b1;
        tk(0, 600);
        rc(8'h00, 32'hffffffff);
        tk(1, 511);
        rc(8'h00, 32'hffffffff);
        tk(1, 1);
        {lat, flag} = 2'b11;
        rc(8'h00, 32'hffffffff);
        rc(8'h04, 32'hffffffff);
        outs;
        rec(32);
        stop <= 1'b0;
        wr(8'h04, 8'h04);
        rc(8'h00, 32'hffffffff);
        wr(8'h04, 8'h02);
        key <= 1'b1;
        @(posedge clk);
        key <= 1'b0;
        flag = 1'b1;
        repeat (2) @(posedge clk);
        outs;
        rc(8'h04, 32'hffffffff);
        wr(8'h04, 8'h04);
        rc(8'h04, 32'hffffffff);
        outs;
        $display("test wake short done");
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        {lat, flag, mask, en, l1, l2} = 6'h00;
        o1 = 8'h00;
        o2 = o2 & 8'h10;
        rc(8'h1e, 32'h000000d3);
        rc(8'h1f, 32'hffffffff);
        wr(8'h1f, d & 8'h3f);
        outs;
        stop <= 1'b1;
        tk(0, wl + 6);
        rc(8'h00, 32'hffffffff);
        outs;
        stop <= 1'b0;
        wr(8'h08, 8'h40);
        stop <= 1'b1;
        tk(0, wl - 1);
        rc(8'h00, 32'hffffffff);
        tk(0, 1);
        {lat, flag} = 2'b11;
        rc(8'h00, 32'hffffffff);
        rec(4096);
        stop <= 1'b0;
        $display("test wake long done");
        final_report;
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        final_report;
    end
endmodule
